// ===== logic/epc_defines.svh
// constants for the encoder position counters
`ifndef EPC_DEFINES_SVH
`define EPC_DEFINES_SVH

`define EPC_CNT_W        16
`define EPC_RES_W        12
`define EPC_ROT_W        12
`define EPC_PROD_W       24
`define EPC_POS_RST      16'h0000
`define EPC_IDX_RST      16'h0000
`define EPC_CNT_MAX      16'hFFFF
`define EPC_RES_RST      12'h000
`define EPC_RES_MAX      12'hFFF
`define EPC_ROT_RST      12'h000
`define EPC_ROT_MAX      12'hE0F
`define EPC_TENTHS_TURN  24'h000E10
`define EPC_RES_SHIFT    12
`define EPC_SYNC_LAT     2

`endif

// ===== logic/epc_pkg.sv
// types shared by the encoder position counter modules
package epc_pkg;

  // phase word is {a, b}; forward means a leads b
  typedef enum logic [1:0]
  {
    EPC_PH_00 = 2'b00,
    EPC_PH_10 = 2'b10,
    EPC_PH_11 = 2'b11,
    EPC_PH_01 = 2'b01
  } epc_phase_t;

  typedef struct packed
  {
    logic step;
    logic up;
    logic bad;
  } epc_move_t;

endpackage

// ===== logic/epc_qdec_if.sv
// carrier between the quadrature decoder and the counters
`timescale 1ns/10ps
interface epc_qdec_if;
  logic step;
  logic up;
  logic index_edge;
  logic bad_edge;
  logic fwd;

  modport dec
  (
    output step,
    output up,
    output index_edge,
    output bad_edge,
    output fwd
  );

  modport cnt
  (
    input step,
    input up,
    input index_edge,
    input bad_edge,
    input fwd
  );
endinterface

// ===== logic/epc_qdec.sv
// quadrature and index decoder with input synchronisers
`timescale 1ns/10ps
`include "epc_defines.svh"
module epc_qdec
(
  input  wire logic   clk_sys,
  input  wire logic   srst,
  input  wire logic   ce,
  input  wire logic   enc_a,
  input  wire logic   enc_b,
  input  wire logic   enc_z,
  epc_qdec_if.dec     dq
);

  logic [2:0]          sy1_q;
  logic [2:0]          sy1_d;
  logic [2:0]          sy2_q;
  logic [2:0]          sy2_d;
  epc_pkg::epc_phase_t ph_q;
  epc_pkg::epc_phase_t ph_d;
  logic                z_q;
  logic                z_d;
  logic                fwd_q;
  logic                fwd_d;
  epc_pkg::epc_move_t  mv;

  // one gray step is a count, two bits at once is noise or overspeed
  function automatic epc_pkg::epc_move_t decode
  (
    input epc_pkg::epc_phase_t prev,
    input logic [1:0]          cur
  );
    epc_pkg::epc_move_t m;
    m = '{step: 1'b0, up: 1'b0, bad: 1'b0};
    case ({prev, cur})
      4'b00_10, 4'b10_11, 4'b11_01, 4'b01_00:
        m = '{step: 1'b1, up: 1'b1, bad: 1'b0};
      4'b00_01, 4'b01_11, 4'b11_10, 4'b10_00:
        m = '{step: 1'b1, up: 1'b0, bad: 1'b0};
      4'b00_11, 4'b11_00, 4'b10_01, 4'b01_10:
        m = '{step: 1'b0, up: 1'b0, bad: 1'b1};
      default:
        m = '{step: 1'b0, up: 1'b0, bad: 1'b0};
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    mv    = decode(ph_q, sy2_q[2:1]);
    sy1_d = sy1_q;
    sy2_d = sy2_q;
    ph_d  = ph_q;
    z_d   = z_q;
    fwd_d = fwd_q;
    if (srst)
    begin
      sy1_d = 3'h0;
      sy2_d = 3'h0;
      ph_d  = epc_pkg::EPC_PH_00;
      z_d   = 1'b0;
      fwd_d = 1'b1;
    end
    else if (ce)
    begin
      sy1_d = {enc_a, enc_b, enc_z};
      sy2_d = sy1_q;
      // a double edge still moves the reference so it is not recounted
      ph_d  = epc_pkg::epc_phase_t'(sy2_q[2:1]);
      z_d   = sy2_q[0];
      if (mv.step)
      begin
        fwd_d = mv.up;
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    sy1_q <= sy1_d;
    sy2_q <= sy2_d;
    ph_q  <= ph_d;
    z_q   <= z_d;
    fwd_q <= fwd_d;
  end

  assign dq.step       = ce & mv.step;
  assign dq.up         = mv.up;
  assign dq.bad_edge   = ce & mv.bad;
  assign dq.index_edge = ce & sy2_q[0] & ~z_q;
  assign dq.fwd        = fwd_q;

  ////////////////////////////////////////////////////////////////////////
  AST_ONE_EDGE_COUNTS: assert property (@(posedge clk_sys) disable iff (srst)
    ce && ($countones(sy2_q[2:1] ^ ph_q) == 1) |-> dq.step)
    else $error("single phase edge did not count");

  AST_DOUBLE_IGNORED: assert property (@(posedge clk_sys) disable iff (srst)
    (sy2_q[2:1] == ~ph_q) |-> !dq.step && (dq.bad_edge == ce))
    else $error("double phase edge was counted");

endmodule

// ===== logic/epc_top.sv
// encoder position counters: quadrature, index, resolver and rotor angle
`timescale 1ns/10ps
`include "epc_defines.svh"
module epc_top
#(
  parameter int CNT_W = `EPC_CNT_W,
  parameter int RES_W = `EPC_RES_W
)
(
  input  wire logic              clk_sys,
  input  wire logic              srst,
  input  wire logic              ce,
  input  wire logic              enc_a,
  input  wire logic              enc_b,
  input  wire logic              enc_z,
  input  wire logic [RES_W-1:0]  resolver_angle_in,
  output logic [CNT_W-1:0]       quadrature_position_count,
  output logic [CNT_W-1:0]       index_revolution_count,
  output logic [RES_W-1:0]       resolver_angle_value,
  output logic [`EPC_ROT_W-1:0]  rotor_angle_value,
  output logic                   direction_fwd,
  output logic                   phase_error
);

  epc_qdec_if           dq ();
  logic [CNT_W-1:0]     pos_q;
  logic [CNT_W-1:0]     pos_d;
  logic [CNT_W-1:0]     idx_q;
  logic [CNT_W-1:0]     idx_d;
  logic [RES_W-1:0]     res_q;
  logic [RES_W-1:0]     res_d;
  logic [`EPC_ROT_W-1:0] rot_q;
  logic [`EPC_ROT_W-1:0] rot_d;
  logic                 err_q;
  logic                 err_d;

  // plain modulo arithmetic gives both wrap directions for free
  function automatic logic [CNT_W-1:0] step_count
  (
    input logic [CNT_W-1:0] val,
    input logic             up
  );
    logic [CNT_W-1:0] one;
    one = CNT_W'(1);
    return up ? CNT_W'(val + one) : CNT_W'(val - one);
  endfunction

  // full resolver turn maps onto 3600 tenths; truncation keeps it below 3600
  function automatic logic [`EPC_ROT_W-1:0] to_tenths
  (
    input logic [RES_W-1:0] ang
  );
    logic [`EPC_PROD_W-1:0] prod;
    prod = `EPC_PROD_W'(ang) * `EPC_TENTHS_TURN;
    return `EPC_ROT_W'(prod >> `EPC_RES_SHIFT);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  epc_qdec i_epc_qdec
  (
    .clk_sys (clk_sys),
    .srst    (srst),
    .ce      (ce),
    .enc_a   (enc_a),
    .enc_b   (enc_b),
    .enc_z   (enc_z),
    .dq      (dq.dec)
  );

  ////////////////////////////////////////////////////////////////////////
  // counters
  always_comb
  begin
    pos_d = pos_q;
    idx_d = idx_q;
    if (srst)
    begin
      pos_d = `EPC_POS_RST;
      idx_d = `EPC_IDX_RST;
    end
    else if (ce)
    begin
      // every lone edge of A or B is one count, so one pulse is four
      if (dq.step)
      begin
        pos_d = step_count(pos_q, dq.up);
      end
      // index has no phase of its own; it follows the last seen direction
      if (dq.index_edge)
      begin
        idx_d = step_count(idx_q, dq.fwd);
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    pos_q <= pos_d;
    idx_q <= idx_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // angle monitors
  always_comb
  begin
    res_d = res_q;
    rot_d = rot_q;
    err_d = 1'b0;
    if (srst)
    begin
      res_d = `EPC_RES_RST;
      rot_d = `EPC_ROT_RST;
    end
    else if (ce)
    begin
      res_d = resolver_angle_in;
      rot_d = to_tenths(resolver_angle_in);
      err_d = dq.bad_edge;
    end
    else
    begin
      err_d = err_q;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    res_q <= res_d;
    rot_q <= rot_d;
    err_q <= err_d;
  end

  assign quadrature_position_count = pos_q;
  assign index_revolution_count    = idx_q;
  assign resolver_angle_value      = res_q;
  assign rotor_angle_value         = rot_q;
  assign direction_fwd             = dq.fwd;
  assign phase_error               = err_q;

  ////////////////////////////////////////////////////////////////////////
  // helper: four forward steps in a row should add exactly four
  logic [2:0]       run_q;
  logic [2:0]       run_d;
  logic [CNT_W-1:0] base_q;
  logic [CNT_W-1:0] base_d;

  always_comb
  begin
    run_d  = run_q;
    base_d = base_q;
    if (srst || !ce || (dq.step && !dq.up))
    begin
      run_d  = 3'h0;
      base_d = pos_q;
    end
    else if (dq.step && run_q == 3'h0)
    begin
      run_d  = 3'h1;
      base_d = pos_q;
    end
    else if (dq.step && run_q < 3'h4)
    begin
      run_d = run_q + 3'h1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    run_q  <= run_d;
    base_q <= base_d;
  end

  AST_FOUR_PER_PULSE: assert property (@(posedge clk_sys) disable iff (srst)
    $rose(run_q == 3'h4) |-> pos_q == CNT_W'(base_q + CNT_W'(4)))
    else $error("four forward edges did not add four");

  AST_COUNT_UP: assert property (@(posedge clk_sys) disable iff (srst)
    ce && dq.step && dq.up |=> pos_q == CNT_W'($past(pos_q) + 1'b1))
    else $error("forward step did not increment position");

  AST_COUNT_DOWN: assert property (@(posedge clk_sys) disable iff (srst)
    ce && dq.step && !dq.up |=> pos_q == CNT_W'($past(pos_q) - 1'b1))
    else $error("reverse step did not decrement position");

  AST_WRAP_UP: assert property (@(posedge clk_sys) disable iff (srst)
    ce && dq.step && dq.up && pos_q == `EPC_CNT_MAX
      |=> pos_q == `EPC_POS_RST)
    else $error("position did not roll over to zero");

  AST_WRAP_DOWN: assert property (@(posedge clk_sys) disable iff (srst)
    ce && dq.step && !dq.up && pos_q == `EPC_POS_RST
      |=> pos_q == `EPC_CNT_MAX)
    else $error("position did not roll under to maximum");

  AST_HOLD_NO_EDGE: assert property (@(posedge clk_sys) disable iff (srst)
    !(ce && dq.step) |=> $stable(pos_q))
    else $error("position moved without a valid edge");

  AST_INDEX_STEP: assert property (@(posedge clk_sys) disable iff (srst)
    ce && dq.index_edge
      |=> idx_q == ($past(dq.fwd) ? CNT_W'($past(idx_q) + 1'b1)
                                  : CNT_W'($past(idx_q) - 1'b1)))
    else $error("index count did not follow direction");

  AST_RESOLVER_TRACK: assert property (@(posedge clk_sys) disable iff (srst)
    ce |=> resolver_angle_value == $past(resolver_angle_in))
    else $error("resolver angle not reported");

  AST_ROTOR_RANGE: assert property (@(posedge clk_sys) disable iff (srst)
    ce && resolver_angle_in == `EPC_RES_MAX
      |=> rotor_angle_value == `EPC_ROT_MAX)
    else $error("rotor angle at full turn is not 359.9 degrees");

  COV_FWD_WRAP: cover property (@(posedge clk_sys) disable iff (srst)
    ce && dq.step && dq.up && pos_q == `EPC_CNT_MAX);

  COV_REV_WRAP: cover property (@(posedge clk_sys) disable iff (srst)
    ce && dq.step && !dq.up && pos_q == `EPC_POS_RST);

  COV_INDEX_REV: cover property (@(posedge clk_sys) disable iff (srst)
    ce && dq.index_edge && !dq.fwd);

  COV_BAD_EDGE: cover property (@(posedge clk_sys) disable iff (srst)
    ce && dq.bad_edge);

endmodule

// ===== dv/epc_enc_model.sv
// behavioural incremental shaft encoder driving phases a, b and index
`timescale 1ns/10ps
module epc_enc_model
(
  input  wire logic clk_sys,
  output logic      enc_a,
  output logic      enc_b,
  output logic      enc_z
);
  // forward order, a leads b
  logic [1:0]  seq [4] = '{2'h0, 2'h2, 2'h3, 2'h1};
  int unsigned pos     = 0;

  initial
  begin
    {enc_a, enc_b} = 2'h0;
    enc_z = 1'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // called just after a falling edge; each state held two clocks
  task automatic quarter(input bit fwd);
    pos = fwd ? (pos + 1) % 4 : (pos + 3) % 4;
    {enc_a, enc_b} = seq[pos];
    repeat (2) @(negedge clk_sys);
  endtask

  task automatic pulses(input int n, input bit fwd);
    repeat (4 * n) quarter(fwd);
  endtask

  // both phases change at once: an illegal move a real encoder can glitch to
  task automatic jump;
    pos = (pos + 2) % 4;
    {enc_a, enc_b} = seq[pos];
    repeat (3) @(negedge clk_sys);
  endtask

  task automatic index;
    enc_z = 1'h1;
    repeat (3) @(negedge clk_sys);
    enc_z = 1'h0;
    repeat (3) @(negedge clk_sys);
  endtask
endmodule

// ===== dv/encoder_position_counters_bench.sv
// self-checking bench for the encoder position counters
`timescale 1ns/10ps
`include "epc_defines.svh"
module encoder_position_counters_bench;
  logic                  clk_sys = 1'h0;
  logic                  srst    = 1'h1;
  logic                  ce      = 1'h1;
  logic [11:0]           resolver_angle_in = 12'h000;
  logic                  enc_a;
  logic                  enc_b;
  logic                  enc_z;
  logic [15:0]           pos_cnt;
  logic [15:0]           idx_cnt;
  logic [11:0]           res_val;
  logic [`EPC_ROT_W-1:0] rot_val;
  logic                  dir_fwd;
  logic                  perr;
  int                    err_total   = 0;
  int                    check_count = 0;

  always #25 clk_sys = ~clk_sys;

  epc_top i_epc_top
  (
    .clk_sys                   (clk_sys),
    .srst                      (srst),
    .ce                        (ce),
    .enc_a                     (enc_a),
    .enc_b                     (enc_b),
    .enc_z                     (enc_z),
    .resolver_angle_in         (resolver_angle_in),
    .quadrature_position_count (pos_cnt),
    .index_revolution_count    (idx_cnt),
    .resolver_angle_value      (res_val),
    .rotor_angle_value         (rot_val),
    .direction_fwd             (dir_fwd),
    .phase_error               (perr)
  );

  epc_enc_model i_epc_enc_model
  (
    .clk_sys (clk_sys),
    .enc_a   (enc_a),
    .enc_b   (enc_b),
    .enc_z   (enc_z)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // three-edge pipeline plus margin
  task automatic settle;
    repeat (4) @(negedge clk_sys);
  endtask

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_count;
    i_epc_enc_model.quarter(1'h1);
    settle;
    check(pos_cnt, 16'h0001);
    repeat (3) i_epc_enc_model.quarter(1'h1);
    i_epc_enc_model.pulses(4, 1'h1);
    settle;
    check(pos_cnt, 16'h0014);
    check({15'h0, dir_fwd}, 16'h0001);
    i_epc_enc_model.pulses(6, 1'h0);
    settle;
    check(pos_cnt, 16'hFFFC);
    check({15'h0, dir_fwd}, 16'h0000);
    i_epc_enc_model.pulses(1, 1'h1);
    settle;
    check(pos_cnt, 16'h0000);
    $display("test count done");
  endtask

  task automatic t_double;
    int seen_err;
    seen_err = 0;
    fork
      begin
        i_epc_enc_model.jump;
        i_epc_enc_model.jump;
        settle;
      end
      repeat (12)
      begin
        @(posedge clk_sys);
        #1;
        if (perr === 1'h1)
          seen_err++;
      end
    join
    // back onto the falling edge so later phase changes stay clear of sampling
    @(negedge clk_sys);
    check(16'(seen_err), 16'h0002);
    check(pos_cnt, 16'h0000);
    $display("test double done");
  endtask

  task automatic t_index;
    i_epc_enc_model.quarter(1'h0);
    i_epc_enc_model.index;
    settle;
    check(idx_cnt, 16'hFFFF);
    i_epc_enc_model.quarter(1'h1);
    i_epc_enc_model.index;
    settle;
    check(idx_cnt, 16'h0000);
    check(pos_cnt, 16'h0000);
    $display("test index done");
  endtask

  task automatic t_resolver;
    logic [11:0] ang [5] = '{12'h000, 12'h001, 12'h800, 12'h471, 12'hFFF};
    foreach (ang[i])
    begin
      resolver_angle_in = ang[i];
      @(negedge clk_sys);
      check({4'h0, res_val}, {4'h0, ang[i]});
      check(16'(rot_val), 16'((32'(ang[i]) * 3600) >> 12));
    end
    $display("test resolver done");
  endtask

  // frozen pipeline misses a whole pulse that ends where it began
  task automatic t_freeze;
    ce = 1'h0;
    i_epc_enc_model.pulses(1, 1'h1);
    ce = 1'h1;
    settle;
    check(pos_cnt, 16'h0000);
    $display("test freeze done");
  endtask

  // mid-run reset with the enable low must still clear every output but direction_fwd, which returns to forward
  task automatic t_reset;
    i_epc_enc_model.pulses(1, 1'h0);
    i_epc_enc_model.index;
    settle;
    check(pos_cnt, 16'hFFFC);
    check(idx_cnt, 16'hFFFF);
    check({15'h0, dir_fwd}, 16'h0000);
    ce   = 1'h0;
    srst = 1'h1;
    @(negedge clk_sys);
    srst = 1'h0;
    ce   = 1'h1;
    check(pos_cnt, 16'h0000);
    check(idx_cnt, 16'h0000);
    check({4'h0, res_val}, 16'h0000);
    check(16'(rot_val), 16'h0000);
    check({15'h0, dir_fwd}, 16'h0001);
    check({15'h0, perr}, 16'h0000);
    settle;
    // phases idle at 00 across reset, so no false edge may be counted
    check(pos_cnt, 16'h0000);
    check({4'h0, res_val}, 16'h0FFF);
    $display("test reset done");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (3) @(negedge clk_sys);
    srst = 1'h0;
    check(pos_cnt, 16'h0000);
    check(idx_cnt, 16'h0000);
    t_count;
    t_double;
    t_index;
    t_resolver;
    t_freeze;
    t_reset;
    give_verdict;
  end

  // run needs well under a thousand cycles
  initial
  begin
    #(3000 * 50);
    err_total++;
    give_verdict;
  end
endmodule
